// ### verilog/lcd_controller.v
// io register front end of the lcd controller: index/data ports and mode selects
`timescale 1ns/1ps
`default_nettype none
`include "lcd_regs_map.vh"
module lcd_controller (
    // clock and reset
    input wire clk,
    input wire rst,
    // host io bus
    input wire [9:0] ioAddr,
    input wire ioRead,
    input wire ioWrite,
    input wire [7:0] ioWriteData,
    output reg [7:0] ioReadData,
    output reg ioReadValid,
    // display side
    output reg panelPowerEnable,
    output reg [1:0] graphicsFormat,
    output reg [19:0] pageBase,
    output reg [11:0] displayStartField,
    output reg [7:0] horizontalRes,
    output reg [7:0] verticalRes,
    output reg [7:0] lcdModeValue,
    output reg panelShiftClock,
    output reg pixelTick
);
    reg [7:0] indexValue;
    reg [7:0] modeFirst;
    reg [7:0] modeSecond;
    reg [7:0] startHigh;
    reg [7:0] startLow;
    reg [7:0] timing1;
    reg [7:0] timing2;
    reg [7:0] timing3;
    reg [7:0] timing4;
    reg [7:0] hres;
    reg [7:0] vres;
    reg [7:0] lcdMode;
    reg [7:0] next_readData;
    reg [7:0] indexedDataValue;
    wire shiftRaw;
    wire tickRaw;

    // indexed register readback
    function [7:0] indexed_read;
        input [7:0] ix;
        begin
            if (ix == `IX_START_HIGH) begin
                indexed_read = startHigh;
            end else if (ix == `IX_START_LOW) begin
                indexed_read = startLow;
            end else if (ix == `IX_TIMING1) begin
                indexed_read = timing1;
            end else if (ix == `IX_TIMING2) begin
                indexed_read = timing2;
            end else if (ix == `IX_TIMING3) begin
                indexed_read = timing3;
            end else if (ix == `IX_TIMING4) begin
                indexed_read = timing4;
            end else if (ix == `IX_HRES) begin
                indexed_read = hres;
            end else if (ix == `IX_VRES) begin
                indexed_read = vres;
            end else if (ix == `IX_LCD_MODE) begin
                indexed_read = lcdMode;
            end else begin
                indexed_read = 8'h00;
            end
        end
    endfunction

    always @* begin
        indexedDataValue = indexed_read(indexValue);
        if (ioAddr == `IO_INDEX_PORT) begin
            next_readData = indexValue;
        end else if (ioAddr == `IO_DATA_PORT) begin
            next_readData = indexedDataValue;
        end else if (ioAddr == `IO_MODE_FIRST) begin
            next_readData = modeFirst;
        end else if (ioAddr == `IO_MODE_SECOND) begin
            next_readData = modeSecond;
        end else begin
            next_readData = 8'h00;
        end
    end

    // reserved bits are masked off on write so they always read zero
    always @(posedge clk) begin
        if (rst) begin
            indexValue <= `RESET_BYTE;
            modeFirst <= `RESET_BYTE;
            modeSecond <= `RESET_BYTE;
            startHigh <= `RESET_BYTE;
            startLow <= `RESET_BYTE;
            timing1 <= `RESET_BYTE;
            timing2 <= `RESET_BYTE;
            timing3 <= `RESET_BYTE;
            timing4 <= `RESET_BYTE;
            hres <= `RESET_BYTE;
            vres <= `RESET_BYTE;
            lcdMode <= `RESET_BYTE;
            ioReadData <= 8'h00;
            ioReadValid <= 1'b0;
        end else begin
            ioReadValid <= ioRead;
            ioReadData <= ioRead ? next_readData : 8'h00;
            if (ioWrite) begin
                if (ioAddr == `IO_INDEX_PORT) begin
                    indexValue <= ioWriteData;
                end else if (ioAddr == `IO_MODE_FIRST) begin
                    modeFirst <= ioWriteData & `MODE_FIRST_MASK;
                end else if (ioAddr == `IO_MODE_SECOND) begin
                    modeSecond <= ioWriteData & `MODE_SECOND_MASK;
                end else if (ioAddr == `IO_DATA_PORT) begin
                    // index is left alone: no auto-increment
                    if (indexValue == `IX_START_HIGH) begin
                        startHigh <= ioWriteData & `START_HIGH_MASK;
                    end else if (indexValue == `IX_START_LOW) begin
                        startLow <= ioWriteData & `START_LOW_MASK;
                    end else if (indexValue == `IX_TIMING1) begin
                        timing1 <= ioWriteData;
                    end else if (indexValue == `IX_TIMING2) begin
                        timing2 <= ioWriteData;
                    end else if (indexValue == `IX_TIMING3) begin
                        timing3 <= ioWriteData;
                    end else if (indexValue == `IX_TIMING4) begin
                        timing4 <= ioWriteData;
                    end else if (indexValue == `IX_HRES) begin
                        hres <= ioWriteData;
                    end else if (indexValue == `IX_VRES) begin
                        vres <= ioWriteData;
                    end else if (indexValue == `IX_LCD_MODE) begin
                        lcdMode <= ioWriteData;
                    end
                end
            end
        end
    end

    // display-side outputs, all registered
    always @(posedge clk) begin
        if (rst) begin
            panelPowerEnable <= 1'b0;
            graphicsFormat <= `FMT_200;
            pageBase <= `PAGE_BASE_LOW;
            displayStartField <= 12'h000;
            horizontalRes <= 8'h00;
            verticalRes <= 8'h00;
            lcdModeValue <= 8'h00;
            panelShiftClock <= 1'b0;
            pixelTick <= 1'b0;
        end else begin
            panelPowerEnable <= modeFirst[`VIDEO_ENABLE_POS];
            if (timing3[`VGA_MODE_POS]) begin
                graphicsFormat <= `FMT_480;
                pageBase <= `VGA_BASE;
            end else if (modeSecond[`FOUR_HUNDRED_POS]) begin
                graphicsFormat <= `FMT_400;
                pageBase <= `PAGE_BASE_LOW;
            end else begin
                graphicsFormat <= `FMT_200;
                // page choice only matters in the 200-line mode
                pageBase <= modeSecond[`PAGE_SELECT_POS] ?
                    `PAGE_BASE_HIGH : `PAGE_BASE_LOW;
            end
            displayStartField <= {startHigh[6:0], startLow[7:3]};
            horizontalRes <= hres;
            verticalRes <= vres;
            lcdModeValue <= lcdMode;
            panelShiftClock <= shiftRaw;
            pixelTick <= tickRaw;
        end
    end

    // clocks only run once the panel is enabled
    shift_clock_gen i_shift_clock_gen (
        .clk(clk),
        .rst(rst),
        .prescale(timing1[7:5]),
        .period(timing1[4:0]),
        .run(panelPowerEnable),
        .pixelTick(tickRaw),
        .panelShiftClock(shiftRaw)
    );
endmodule // lcd_controller
`default_nettype wire

// ### verilog/lcd_regs_map.vh
// register map, field positions and reset values of the lcd controller register port
`ifndef LCD_REGS_MAP_VH
`define LCD_REGS_MAP_VH
`define IO_INDEX_PORT 10'h3D4
`define IO_DATA_PORT 10'h3D5
`define IO_MODE_FIRST 10'h3D8
`define IO_MODE_SECOND 10'h3DE
`define IX_START_HIGH 8'h0C
`define IX_START_LOW 8'h0D
`define IX_TIMING1 8'hC6
`define IX_TIMING2 8'hC7
`define IX_TIMING3 8'hC8
`define IX_TIMING4 8'hC9
`define IX_HRES 8'hCA
`define IX_VRES 8'hCB
`define IX_LCD_MODE 8'hCC
`define VIDEO_ENABLE_POS 3
`define PAGE_SELECT_POS 3
`define FOUR_HUNDRED_POS 0
`define VGA_MODE_POS 6
`define RESET_BYTE 8'h00
`define START_HIGH_MASK 8'h7F
`define START_LOW_MASK 8'hF8
`define MODE_FIRST_MASK 8'h08
`define MODE_SECOND_MASK 8'h09
`define PAGE_BASE_LOW 20'hB8000
`define PAGE_BASE_HIGH 20'hBC000
`define VGA_BASE 20'hA0000
`define FMT_200 2'h0
`define FMT_400 2'h1
`define FMT_480 2'h2
`define SHIFT_MIN 6'h02
`endif

// ### verilog/shift_clock_gen.v
// pixel clock prescaler and panel shift clock generator
`timescale 1ns/1ps
`default_nettype none
`include "lcd_regs_map.vh"
module shift_clock_gen (
    // clock and reset
    input wire clk,
    input wire rst,
    // settings
    input wire [2:0] prescale,
    input wire [4:0] period,
    input wire run,
    // outputs
    output reg pixelTick,
    output reg panelShiftClock
);
    reg [6:0] preCount;
    reg [5:0] shiftCount;
    wire [6:0] preLast = (7'h01 << prescale) - 7'h01;
    // period + 1 pixel clocks, never below two
    wire [5:0] sum = {1'b0, period} + 6'h01;
    wire [5:0] shiftLen = (sum < `SHIFT_MIN) ? `SHIFT_MIN : sum;
    always @(posedge clk) begin
        if (rst || !run) begin
            preCount <= 7'h00;
            shiftCount <= 6'h00;
            pixelTick <= 1'b0;
            panelShiftClock <= 1'b0;
        end else begin
            pixelTick <= (preCount >= preLast);
            preCount <= (preCount >= preLast) ? 7'h00 : preCount + 7'h01;
            if (preCount >= preLast) begin
                if (shiftCount >= shiftLen - 6'h01) begin
                    shiftCount <= 6'h00;
                    panelShiftClock <= 1'b1;
                end else begin
                    shiftCount <= shiftCount + 6'h01;
                    // high for the first half of each period
                    panelShiftClock <= (shiftCount + 6'h01) < (shiftLen >> 1);
                end
            end
        end
    end
endmodule // shift_clock_gen
`default_nettype wire

// ### bench/lcd_controller_monitor.sv
// concurrent checks on the lcd controller register port
`timescale 1ns/1ps
`default_nettype none
module lcd_controller_monitor (
    // clock and reset
    input wire clk,
    input wire rst,
    // host io bus
    input wire [9:0] ioAddr,
    input wire ioRead,
    input wire ioWrite,
    input wire [7:0] ioWriteData,
    input wire [7:0] ioReadData,
    input wire ioReadValid,
    // display side
    input wire panelPowerEnable,
    input wire [1:0] graphicsFormat,
    input wire [19:0] pageBase,
    input wire [11:0] displayStartField,
    input wire panelShiftClock,
    input wire pixelTick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_read_answer: assert property (ioRead |=> ioReadValid) else $error("no answer");
    chk_valid_cause: assert property (ioReadValid |-> $past(ioRead)) else $error("stray");
    chk_data_idle: assert property (!ioReadValid |-> ioReadData == 8'h00) else $error("data");
    chk_power_follow: assert property (ioWrite && ioAddr == 10'h3D8 |-> ##2
        panelPowerEnable == $past(ioWriteData[3], 2)) else $error("power");
    // the clocks pass two flops after the enable drops, so three dark cycles are awaited
    chk_dark_panel: assert property (!panelPowerEnable && $past(!panelPowerEnable)
        && $past(!panelPowerEnable, 2) |-> !pixelTick && !panelShiftClock)
        else $error("clock while dark");
    chk_page_low: assert property (graphicsFormat == 2'h0 |->
        pageBase == 20'hB8000 || pageBase == 20'hBC000) else $error("page");
    chk_page_vga: assert property (graphicsFormat == 2'h2 |-> pageBase == 20'hA0000)
        else $error("vga page");
    chk_page_mid: assert property (graphicsFormat == 2'h1 |-> pageBase == 20'hB8000)
        else $error("400 page");
    chk_start_cause: assert property ($changed(displayStartField) |->
        $past(ioWrite && ioAddr == 10'h3D5, 2)) else $error("start moved");
endmodule // lcd_controller_monitor
bind lcd_controller lcd_controller_monitor i_lcd_controller_monitor (.clk(clk), .rst(rst),
    .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite), .ioWriteData(ioWriteData),
    .ioReadData(ioReadData), .ioReadValid(ioReadValid), .panelPowerEnable(panelPowerEnable),
    .graphicsFormat(graphicsFormat), .pageBase(pageBase), .displayStartField(displayStartField),
    .panelShiftClock(panelShiftClock), .pixelTick(pixelTick));
`default_nettype wire

// ### bench/host_cpu_model.sv
// host cpu model: one strobed io access per request cycle
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    // clock and request
    input wire logic clk,
    input wire logic go,
    input wire logic wr,
    input wire logic [9:0] addr,
    input wire logic [7:0] data,
    // io bus
    output logic [9:0] ioAddr = 10'h000,
    output logic ioRead = 1'b0,
    output logic ioWrite = 1'b0,
    output logic [7:0] ioWriteData = 8'h00
);
    always @(posedge clk) begin
        ioRead <= go && !wr;
        ioWrite <= go && wr;
        // idle bus shows the inverse of its last value, so the old address comes back on every second idle cycle
        ioAddr <= go ? addr : ~ioAddr;
        ioWriteData <= go ? data : ~ioWriteData;
    end
endmodule // host_cpu_model
`default_nettype wire

// ### bench/test_lcd_controller.sv
// self-checking testbench of the lcd controller register port
`timescale 1ns/1ps
`default_nettype none
module test_lcd_controller;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] data = 8'h00;
    logic last;
    wire [9:0] ioAddr;
    wire [7:0] ioWriteData, ioReadData, horizontalRes, verticalRes, lcdModeValue;
    wire ioRead, ioWrite, ioReadValid, panelPowerEnable, panelShiftClock, pixelTick;
    wire [1:0] graphicsFormat;
    wire [19:0] pageBase;
    wire [11:0] displayStartField;
    logic [7:0] expQ [$];
    logic [7:0] v [9];
    int n_mismatch = 0;
    int checks_done = 0;
    int i, j, t, p;
    always #12.5 clk = ~clk;
    host_cpu_model i_host_cpu_model (.clk(clk), .go(go), .wr(wr), .addr(addr), .data(data),
        .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite), .ioWriteData(ioWriteData));
    lcd_controller i_lcd_controller (.clk(clk), .rst(rst), .ioAddr(ioAddr), .ioRead(ioRead),
        .ioWrite(ioWrite), .ioWriteData(ioWriteData), .ioReadData(ioReadData),
        .ioReadValid(ioReadValid), .panelPowerEnable(panelPowerEnable),
        .graphicsFormat(graphicsFormat), .pageBase(pageBase), .displayStartField(displayStartField),
        .horizontalRes(horizontalRes), .verticalRes(verticalRes), .lcdModeValue(lcdModeValue),
        .panelShiftClock(panelShiftClock), .pixelTick(pixelTick));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // go stays up across back-to-back accesses; only idle lowers it
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        data <= d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expQ.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
    task automatic idle(input int n);
        go <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [7:0] ix(input int k);
        return (k < 2) ? 8'(8'h0C + k) : 8'(8'hC4 + k);
    endfunction
    always @(posedge clk) begin
        if (ioReadValid === 1'b1) begin
            if (expQ.size() == 0)
                check(1'b1, 1'b0);
            else
                check(ioReadData, expQ.pop_front());
        end
    end
    initial begin
        t = $urandom(47);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(pageBase, 20'hB8000);
        rd(10'h3D8, 8'h00);
        rd(10'h3DE, 8'h00);
        acc(1'b1, 10'h3D4, 8'h0C);
        rd(10'h3D5, 8'h00);
        rd(10'h3D0, 8'h00);
        acc(1'b1, 10'h3D4, 8'h10);
        rd(10'h3D5, 8'h00);
        for (i = 0; i < 9; i++) begin
            v[i] = $urandom & (i == 0 ? 8'h7F : i == 1 ? 8'hF8 : i == 4 ? 8'hBF : 8'hFF);
            acc(1'b1, 10'h3D4, ix(i));
            acc(1'b1, 10'h3D5, v[i]);
        end
        for (i = 0; i < 9; i++) begin
            acc(1'b1, 10'h3D4, ix(i));
            rd(10'h3D5, v[i]);
            rd(10'h3D5, v[i]);
            rd(10'h3D4, ix(i));
        end
        idle(5);
        check(displayStartField, {v[0][6:0], v[1][7:3]});
        check({horizontalRes, verticalRes, lcdModeValue}, {v[6], v[7], v[8]});
        acc(1'b1, 10'h3DE, 8'h01);
        idle(5);
        check({graphicsFormat, pageBase}, {2'h1, 20'hB8000});
        acc(1'b1, 10'h3DE, 8'h08);
        idle(5);
        check({graphicsFormat, pageBase}, {2'h0, 20'hBC000});
        acc(1'b1, 10'h3D4, 8'hC8);
        acc(1'b1, 10'h3D5, 8'h40);
        idle(5);
        check({graphicsFormat, pageBase}, {2'h2, 20'hA0000});
        acc(1'b1, 10'h3D8, 8'h08);
        idle(5);
        check(panelPowerEnable, 1'b1);
        // any 100 clocks of a steady shift clock hold an exact number of rises
        for (j = 0; j < 2; j++) begin
            acc(1'b1, 10'h3D4, 8'hC6);
            acc(1'b1, 10'h3D5, j ? 8'h00 : 8'h24);
            idle(40);
            t = 0;
            p = 0;
            last = panelShiftClock;
            for (i = 0; i < 100; i++) begin
                @(posedge clk);
                if (panelShiftClock === 1'b1 && last === 1'b0)
                    t++;
                if (pixelTick === 1'b1)
                    p++;
                last = panelShiftClock;
            end
            check(t, j ? 50 : 10);
            check(p, j ? 100 : 50);
        end
        // panel off again: both clocks must stop
        acc(1'b1, 10'h3D8, 8'h00);
        idle(6);
        check({panelPowerEnable, panelShiftClock, pixelTick}, 3'h0);
        acc(1'b1, 10'h3D8, 8'h08);
        rd(10'h3D8, 8'h08);
        idle(4);
        // hard reset in mid-run: enable, start address and mode bits fall back to zero
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({panelPowerEnable, displayStartField}, 13'h0000);
        rd(10'h3D8, 8'h00);
        rd(10'h3DE, 8'h00);
        idle(4);
        check(expQ.size(), 0);
        wrap_up();
    end
endmodule // test_lcd_controller
`default_nettype wire
